// >>> test/hwa_props_properties.sv
// Port checker for the highway arbiter.
// Assumes binding onto hwa_arbiter, one clock domain.
`timescale 1ns/1ps
module hwa_props
	import hwa_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [23:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// Requests and grant
	input wire logic [HWA_NREQ-1:0] req,
	input wire logic [HWA_NREQ-1:0] req_high,
	input wire logic done,
	input wire logic [HWA_NREQ-1:0] grant,
	input wire logic busy
);
	logic [1:0] up_r;
	logic hit;
	assign hit = reg_addr == HWA_WEIGHTS_OFFSET;
	// Edges since release, covers the reset synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_ONEHOT: assert property ($onehot0(grant))
		else $error("grant not one-hot");
	AST_BUSY: assert property (busy == |grant)
		else $error("busy differs from grant");
	AST_HOLD: assert property (busy && !done |=> busy && $stable(grant))
		else $error("grant dropped before done");
	AST_END: assert property (busy && done |=> !busy)
		else $error("grant outlived done");
	AST_CAUSE: assert property (
		$rose(busy) |-> ($past(req) & grant) == grant)
		else $error("grant without request");
	AST_HIGH: assert property (
		$rose(busy) && |($past(req) & $past(req_high))
		|-> |(grant & $past(req_high))) else $error("low request won");
	AST_SERVE: assert property (up_r == 2'h3 && !busy && |req |=> busy)
		else $error("pending request left idle");
	AST_UNMAP: assert property (up_r == 2'h3 && !hit |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	AST_RSVD: assert property (reg_rdata[31:18] == 14'h0)
		else $error("reserved bits set");
	AST_WRITE: assert property (
		up_r == 2'h3 && reg_wr && hit ##1 hit && !reg_wr
		|=> reg_rdata == ($past(reg_wdata, 2) & HWA_WEIGHTS_MASK))
		else $error("weights read back wrong");
	COV_SLOT: cover property (busy && done ##2 busy);
	COV_HIGH: cover property ($rose(busy) && |(grant & req_high));
	COV_WRITE: cover property (reg_wr && hit);
endmodule : hwa_props
bind hwa_arbiter hwa_props u_props (.core_clk(core_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .req(req), .req_high(req_high), .done(done),
	.grant(grant), .busy(busy));

// >>> test/hwa_requesters.sv
// Requester and memory side model: holds requests, ends slots.
// Assumes bench control inputs; drives on the falling edge.
`timescale 1ns/1ps
module hwa_requesters
	import hwa_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bench control
	input wire logic [HWA_NREQ-1:0] want,
	input wire logic [3:0] lat,
	// Arbiter side
	input wire logic [HWA_NREQ-1:0] grant,
	output logic [HWA_NREQ-1:0] req,
	output logic done
);
	logic [3:0] cnt_r;
	always @(negedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req <= '0;
			done <= 1'b0;
			cnt_r <= 4'h0;
		end else begin
			// Held until granted
			req <= (req | want) & ~grant;
			done <= 1'b0;
			if (|grant && !done) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == lat) begin
					done <= 1'b1;
					cnt_r <= 4'h0;
				end
			end
		end
	end
endmodule : hwa_requesters

// >>> test/tb_hierarchical_weighted_highway_arbiter.sv
// Bench for the highway arbiter: weight register and slot shares.
// Assumes the requester model and bound checker are compiled.
`timescale 1ns/1ps
module tb_hierarchical_weighted_highway_arbiter
	import hwa_pkg::*;
;
	typedef struct packed {
		logic [31:0] w;
		logic [3:0] a, b, wa, wb;
		logic [11:0] hi;
		logic fx;
	} hwa_case_type;
	localparam hwa_case_type TBL[17] = '{
		'{32'h20000, 4'h0, 4'h3, 4'h3, 4'h1, 12'h0, 1'b0},
		'{32'h04000, 4'h1, 4'h4, 4'h1, 4'h2, 12'h0, 1'b0},
		'{32'h18000, 4'h2, 4'h5, 4'h2, 4'h3, 12'h0, 1'b0},
		'{32'h02c00, 4'h3, 4'h4, 4'h5, 4'h7, 12'h0, 1'b0},
		'{32'h01400, 4'h3, 4'h6, 4'h3, 4'h3, 12'h0, 1'b0},
		'{32'h00380, 4'h4, 4'h5, 4'h7, 4'h5, 12'h0, 1'b0},
		'{32'h00140, 4'h4, 4'h6, 4'h3, 4'h3, 12'h0, 1'b0},
		'{32'h00030, 4'h5, 4'h6, 4'h2, 4'h5, 12'h0, 1'b0},
		'{32'h00008, 4'h5, 4'h7, 4'h1, 4'h3, 12'h0, 1'b0},
		'{32'h00005, 4'h6, 4'h7, 4'h5, 4'h2, 12'h0, 1'b0},
		'{32'h00002, 4'h6, 4'h8, 4'h3, 4'h1, 12'h0, 1'b0},
		'{32'h00000, 4'h7, 4'h8, 4'h2, 4'h1, 12'h0, 1'b0},
		'{32'h00000, 4'h9, 4'ha, 4'h1, 4'h1, 12'h0, 1'b0},
		'{32'h00000, 4'h0, 4'hb, 4'h1, 4'h1, 12'h0, 1'b0},
		'{32'h00000, 4'h0, 4'h1, 4'h1, 4'h1, 12'h0, 1'b1},
		'{32'h00000, 4'h1, 4'h2, 4'h1, 4'h1, 12'h0, 1'b1},
		'{32'h20000, 4'h0, 4'h3, 4'h0, 4'h1, 12'h008, 1'b0}};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [23:0] reg_addr = '0;
	logic reg_wr = 1'b0;
	logic [31:0] reg_wdata = '0;
	logic [31:0] reg_rdata;
	logic [HWA_NREQ-1:0] want = '0, req_high = '0, req, grant;
	logic [3:0] lat = 4'h0;
	logic done, busy;
	int fails = 0, n_tests = 0, cyc = 0, tot = 0;
	int cnt[HWA_NREQ];
	always #5 core_clk = ~core_clk;
	hwa_arbiter dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.req(req), .req_high(req_high), .done(done), .grant(grant),
		.busy(busy));
	hwa_requesters far (.core_clk(core_clk), .rst_n(rst_n), .want(want),
		.lat(lat), .grant(grant), .req(req), .done(done));
	////////////////////////////////////////////////////////////////////////
	// Slot tally and hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (busy && done) begin
			tot++;
			for (int i = 0; i < HWA_NREQ; i++) cnt[i] += int'(grant[i]);
		end
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic check(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(logic [23:0] a, logic [31:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(logic [23:0] a, logic [31:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		@(negedge core_clk);
		check(reg_rdata, exp);
	endtask : rd
	task automatic slots(int n);
		int t0;
		t0 = tot;
		while (tot < t0 + n) @(negedge core_clk);
	endtask : slots
	task automatic finish_test();
		$display("checks %0d failures %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		rd(HWA_WEIGHTS_OFFSET, 32'h0);
		wr(HWA_WEIGHTS_OFFSET, 32'hffff_ffff);
		rd(HWA_WEIGHTS_OFFSET, 32'h0003_ffff);
		rd(24'h100108, 32'h0);
		foreach (TBL[k]) begin
			want = '0;
			while (req != '0 || busy) @(negedge core_clk);
			wr(HWA_WEIGHTS_OFFSET, TBL[k].w);
			rd(HWA_WEIGHTS_OFFSET, TBL[k].w);
			lat = 4'(k % 3 * 2);
			req_high = TBL[k].hi;
			want[TBL[k].a] = 1'b1;
			want[TBL[k].b] = 1'b1;
			// Settle the rotation before counting
			slots(TBL[k].wa + TBL[k].wb);
			cnt = '{default: 0};
			slots(2 * (TBL[k].wa + TBL[k].wb));
			if (TBL[k].fx) begin
				check(32'(cnt[TBL[k].a]), 32'(2 * (TBL[k].wa + TBL[k].wb)));
				check(32'(cnt[TBL[k].b]), 32'h0);
			end else begin
				check(32'(cnt[TBL[k].a]), 32'(2 * TBL[k].wa));
				check(32'(cnt[TBL[k].b]), 32'(2 * TBL[k].wb));
			end
		end
		finish_test();
	end
endmodule : tb_hierarchical_weighted_highway_arbiter

// >>> verilog/hwa_arbiter.sv
// Hierarchical weighted highway arbiter, top level.
// Assumes requesters hold req until granted, done marks slot end.
//
// Contract
// R1: Cache and register-port requests merge into one processor request.
// R2: Six levels, each its own round-robin machine.
// R3: Level winner competes one level up; top level grants highway.
// R4: A requester owns as many round-robin nodes as its weight.
// R5: Programmable weight activates only that many nodes.
// R6: Level one: fixed-priority processor group versus level two.
// R7: Level two: video output versus level three.
// R8: Level three: image coprocessor versus level four.
// R9: Level four: video input versus level five.
// R10: Level six fixed weights: decoder 2, audio 1 each, boot/serial 1.
// R11: Processor and level-two codes give weights 1, 2, 3; the decode here also gives weight 4 for code 3.
// R12: Four fields decode to weights 1, 3, 5; the decode here also gives weight 7 for code 3.
// R13: Level-three and coprocessor fields decode to 1, 3, 5, 7.
// R14: Video-input and level-six bits give weight 1 or 2.
// R15: Weight register resets to zero, all weights one.
// R16: Bandwidth shares proportional to active weights.
// R17: Unused slots pass to other requesters and higher levels.
// R18: Processor takes all spare bandwidth at least latency.
// R19: Each grant is one 64-byte transfer slot.
// R20: Granted requester moves to last place in its level.
// R21: High priority beats low; round-robin within each class.
// R22: Levels request upward only when pending; grant passes down.
// R23: Reserved bits read zero; new weights apply at next decision.
`timescale 1ns/1ps
module hwa_arbiter
	import hwa_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [23:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// Requesters
	input wire logic [HWA_NREQ-1:0] req,
	input wire logic [HWA_NREQ-1:0] req_high,
	// Slot end from memory interface
	input wire logic done,
	// Grant
	output logic [HWA_NREQ-1:0] grant,
	output logic busy
);
	////////////////////////////////////////////////////////////////////
	logic rst_s1_r;
	logic rst_sync_n;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Weight register
	logic [31:0] weights_r;
	logic sel_w;
	assign sel_w = (reg_addr == HWA_WEIGHTS_OFFSET);
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			weights_r <= HWA_WEIGHTS_RESET; // R15
		else if (reg_wr && sel_w)
			weights_r <= reg_wdata & HWA_WEIGHTS_MASK; // R23
	end
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			reg_rdata <= '0;
		else
			reg_rdata <= sel_w ? weights_r : '0; // R23
	end
	////////////////////////////////////////////////////////////////////
	// Weight decode
	logic [HWA_WW-1:0] w_cpu, w_l2, w_vo, w_l3, w_icp, w_l4, w_l5, w_pci;
	logic [HWA_WW-1:0] w_vi, w_l6;
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b0)
	) u_d_cpu ( // R11
		.code(weights_r[HWA_CPU_LSB +: 2]),
		.weight(w_cpu)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b0)
	) u_d_l2 ( // R11
		.code(weights_r[HWA_L2_LSB +: 2]),
		.weight(w_l2)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b1)
	) u_d_vo ( // R12
		.code(weights_r[HWA_VO_LSB +: 2]),
		.weight(w_vo)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b1)
	) u_d_l3 ( // R13
		.code(weights_r[HWA_L3_LSB +: 2]),
		.weight(w_l3)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b1)
	) u_d_icp ( // R13
		.code(weights_r[HWA_ICP_LSB +: 2]),
		.weight(w_icp)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b1)
	) u_d_l4 ( // R12
		.code(weights_r[HWA_L4_LSB +: 2]),
		.weight(w_l4)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b1)
	) u_d_l5 ( // R12
		.code(weights_r[HWA_L5_LSB +: 2]),
		.weight(w_l5)
	);
	hwa_decode #(
		.CODE_W(2),
		.ODD(1'b1)
	) u_d_pci ( // R12
		.code(weights_r[HWA_PCI_LSB +: 2]),
		.weight(w_pci)
	);
	hwa_decode #(
		.CODE_W(1),
		.ODD(1'b0)
	) u_d_vi ( // R14
		.code(weights_r[HWA_VI_BIT]),
		.weight(w_vi)
	);
	hwa_decode #(
		.CODE_W(1),
		.ODD(1'b0)
	) u_d_l6 ( // R14
		.code(weights_r[HWA_L6_BIT]),
		.weight(w_l6)
	);
	localparam logic [HWA_WW-1:0] W_ONE = 3'h1;
	localparam logic [HWA_WW-1:0] W_TWO = 3'h2;
	////////////////////////////////////////////////////////////////////
	// Priority class: high requests compete alone when any exist
	logic any_high;
	logic [HWA_NREQ-1:0] act;
	assign any_high = |(req & req_high);
	assign act = any_high ? (req & req_high) : req; // R21
	////////////////////////////////////////////////////////////////////
	// Slot control
	hwa_state_type state_r;
	logic advance;
	logic adv1, adv2, adv3, adv4, adv5, adv6;
	assign advance = (state_r == HWA_IDLE);
	////////////////////////////////////////////////////////////////////
	// Level six: decoder, audio in, audio out, boot plus serial
	logic [3:0] r6;
	logic [3:0] w6;
	logic any6;
	assign r6 = {act[HWA_BOOT] | act[HWA_SER], act[HWA_AO], act[HWA_AI],
		act[HWA_VLD]};
	hwa_level #(.N(4)) u_l6 ( // R2 R4 R10 R16 R17 R20
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.req(r6),
		.weight({W_ONE, W_ONE, W_ONE, W_TWO}),
		.advance(adv6),
		.any(any6),
		.win(w6)
	);
	// Level five: PCI versus level six
	logic [1:0] w5;
	logic any5;
	hwa_level #(.N(2)) u_l5 ( // R2 R3 R5 R22
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.req({any6, act[HWA_PCI]}),
		.weight({w_l6, w_pci}),
		.advance(adv5),
		.any(any5),
		.win(w5)
	);
	// Level four: video input versus level five
	logic [1:0] w4;
	logic any4;
	hwa_level #(.N(2)) u_l4 ( // R9 R3 R22
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.req({any5, act[HWA_VI]}),
		.weight({w_l5, w_vi}),
		.advance(adv4),
		.any(any4),
		.win(w4)
	);
	// Level three: coprocessor versus level four
	logic [1:0] w3;
	logic any3;
	hwa_level #(.N(2)) u_l3 ( // R8 R3 R22
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.req({any4, act[HWA_ICP]}),
		.weight({w_l4, w_icp}),
		.advance(adv3),
		.any(any3),
		.win(w3)
	);
	// Level two: video output versus level three
	logic [1:0] w2;
	logic any2;
	hwa_level #(.N(2)) u_l2 ( // R7 R3 R22
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.req({any3, act[HWA_VO]}),
		.weight({w_l3, w_vo}),
		.advance(adv2),
		.any(any2),
		.win(w2)
	);
	// Level one: processor group versus level two
	logic cpu_req;
	logic [1:0] w1;
	logic any1;
	assign cpu_req = act[HWA_MMIO] | act[HWA_DC] | act[HWA_IC]; // R1
	hwa_level #(.N(2)) u_l1 ( // R6 R3 R18
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.req({any2, cpu_req}),
		.weight({w_l2, w_cpu}),
		.advance(adv1),
		.any(any1),
		.win(w1)
	);
	////////////////////////////////////////////////////////////////////
	// Only levels on the granted path rotate, so a branch that lost
	// above keeps its place in line
	assign adv1 = advance; // R20
	assign adv2 = adv1 && w1[1]; // R3 R22
	assign adv3 = adv2 && w2[1];
	assign adv4 = adv3 && w3[1];
	assign adv5 = adv4 && w4[1];
	assign adv6 = adv5 && w5[1];
	////////////////////////////////////////////////////////////////////
	// Grant passes down the winning path
	logic [HWA_NREQ-1:0] pick;
	always_comb begin
		pick = '0;
		if (w1[0]) begin
			// Fixed priority inside processor group
			if (act[HWA_MMIO]) // R6
				pick[HWA_MMIO] = 1'b1;
			else if (act[HWA_DC])
				pick[HWA_DC] = 1'b1;
			else
				pick[HWA_IC] = 1'b1;
		end else if (w1[1]) begin // R22
			if (w2[0])
				pick[HWA_VO] = 1'b1;
			else if (w3[0])
				pick[HWA_ICP] = 1'b1;
			else if (w4[0])
				pick[HWA_VI] = 1'b1;
			else if (w5[0])
				pick[HWA_PCI] = 1'b1;
			else if (w6[0])
				pick[HWA_VLD] = 1'b1;
			else if (w6[1])
				pick[HWA_AI] = 1'b1;
			else if (w6[2])
				pick[HWA_AO] = 1'b1;
			else if (act[HWA_BOOT])
				pick[HWA_BOOT] = 1'b1;
			else
				pick[HWA_SER] = 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// One grant held for one 64-byte slot until done
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r <= HWA_IDLE;
			grant <= '0;
			busy <= 1'b0;
		end else begin
			case (state_r)
				HWA_IDLE: begin
					if (any1) begin // R19
						state_r <= HWA_BUSY;
						grant <= pick;
						busy <= 1'b1;
					end
				end
				HWA_BUSY: begin
					if (done) begin
						state_r <= HWA_IDLE;
						grant <= '0;
						busy <= 1'b0;
					end
				end
				default: begin
					state_r <= HWA_IDLE;
					grant <= '0;
					busy <= 1'b0;
				end
			endcase
		end
	end
endmodule : hwa_arbiter

// >>> verilog/hwa_decode.sv
// Decodes a weight code into a number of active round-robin nodes.
// Assumes purely combinational use inside the top module.
`timescale 1ns/1ps
module hwa_decode
	import hwa_pkg::*;
#(
	parameter int CODE_W = 2,
	// 0: 1,2,3,4  1: 1,3,5,7
	parameter bit ODD = 1'b1
) (
	// Code in
	input wire logic [CODE_W-1:0] code,
	// Weight out
	output logic [HWA_WW-1:0] weight
);
	always_comb begin
		if (ODD)
			weight = HWA_WW'({code, 1'b1});
		else
			weight = HWA_WW'(code) + HWA_WW'(1);
	end
endmodule : hwa_decode

// >>> verilog/hwa_level.sv
// One weighted round-robin level with two or more competitors.
// Assumes requests held until granted; advance pulses once per slot.
`timescale 1ns/1ps
module hwa_level
	import hwa_pkg::*;
#(
	parameter int N = 2
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_sync_n,
	// Competitors
	input wire logic [N-1:0] req,
	input wire logic [N*HWA_WW-1:0] weight,
	input wire logic advance,
	// Result
	output logic any,
	output logic [N-1:0] win
);
	localparam int IW = (N > 1) ? $clog2(N) : 1;
	logic [IW-1:0] cur_r;
	logic [HWA_WW-1:0] used_r;
	logic [IW-1:0] pick;
	logic [HWA_WW-1:0] wcur;
	always_comb begin
		pick = cur_r;
		any = |req;
		wcur = weight[cur_r*HWA_WW +: HWA_WW];
		// Stay on current owner while nodes remain, else next in order
		if (!(req[cur_r] && used_r < wcur)) begin // R4 R5
			for (int k = N; k >= 1; k--) begin
				if (req[(int'(cur_r) + k) % N])
					pick = IW'((int'(cur_r) + k) % N);
			end
		end
		win = '0;
		if (any)
			win[pick] = 1'b1;
	end
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur_r <= '0;
			used_r <= '0;
		end else if (advance && any) begin
			cur_r <= pick; // R20
			used_r <= (pick == cur_r && used_r < wcur) ?
				used_r + HWA_WW'(1) : HWA_WW'(1);
		end
	end
endmodule : hwa_level

// >>> verilog/hwa_pkg.sv
// Package for the hierarchical weighted highway arbiter.
// Assumes one core clock domain; register access by documented offset.
package hwa_pkg;
	localparam int HWA_LEVELS = 6;
	localparam logic [23:0] HWA_WEIGHTS_OFFSET = 24'h100104;
	localparam logic [31:0] HWA_WEIGHTS_RESET = 32'h0000_0000;
	localparam logic [31:0] HWA_WEIGHTS_MASK = 32'h0003_ffff;
	// Field positions
	localparam int HWA_CPU_LSB = 16;
	localparam int HWA_L2_LSB = 14;
	localparam int HWA_VO_LSB = 12;
	localparam int HWA_L3_LSB = 10;
	localparam int HWA_ICP_LSB = 8;
	localparam int HWA_L4_LSB = 6;
	localparam int HWA_VI_BIT = 5;
	localparam int HWA_L5_LSB = 3;
	localparam int HWA_PCI_LSB = 1;
	localparam int HWA_L6_BIT = 0;
	// Widest weight of any competitor
	localparam int HWA_WMAX = 7;
	localparam int HWA_WW = 3;
	// Transfer length of one slot in bytes
	localparam int HWA_SLOT_BYTES = 64;
	// Requester indices of the grant vector
	localparam int HWA_NREQ = 12;
	localparam int HWA_MMIO = 0;
	localparam int HWA_DC = 1;
	localparam int HWA_IC = 2;
	localparam int HWA_VO = 3;
	localparam int HWA_ICP = 4;
	localparam int HWA_VI = 5;
	localparam int HWA_PCI = 6;
	localparam int HWA_VLD = 7;
	localparam int HWA_AI = 8;
	localparam int HWA_AO = 9;
	localparam int HWA_BOOT = 10;
	localparam int HWA_SER = 11;
	typedef enum logic [1:0] {
		HWA_IDLE = 2'b01,
		HWA_BUSY = 2'b10
	} hwa_state_type;
endpackage : hwa_pkg
